// ===== cobl_chk_asserts.sv
// checker for cobl_top: option outputs against read data and write lock
// assumes it is bound to cobl_top and ARST_N is the power-on reset
`timescale 1ns/1ps
`include "cobl_defs.vh"
module cobl_chk (
  input wire        CLK,
  input wire        ARST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [31:0] PADDR,
  input wire [3:0]  PSTRB,
  input wire [31:0] PRDATA,
  input wire        STACK_FAULT,
  input wire        DEBUGGER_ENABLE,
  input wire        DEBUG_PINS_OWNED,
  input wire        EXTENDED_ISA_ENABLE,
  input wire        STACK_FAULT_RESET,
  input wire        WATCHDOG_RUN
);
  localparam logic [31:0] OPT = `COBL_ADDR_OPTION;
  logic prog_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_rd;
    PSEL && PENABLE && !PWRITE && PADDR == OPT;
  endsequence
  sequence s_wr;
    PSEL && PENABLE && PWRITE && PADDR == OPT && PSTRB[0];
  endsequence
  // a first write locks every implemented bit, so later writes must leave the debug and isa outputs alone
  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N) prog_q <= 1'b0;
    else if (PSEL && PENABLE && PWRITE && PADDR == OPT && PSTRB[0])
      prog_q <= 1'b1;
  a_debug_bit: assert property (s_rd |-> PRDATA[7] != DEBUGGER_ENABLE
    && PRDATA[7] != DEBUG_PINS_OWNED) else $error("debug bit");
  a_xisa_bit: assert property (s_rd |->
    PRDATA[6] == EXTENDED_ISA_ENABLE) else $error("isa bit");
  a_wdog_forced: assert property (s_rd ##0 PRDATA[0] |-> WATCHDOG_RUN)
    else $error("watchdog bit");
  a_unimpl_zero: assert property (s_rd |-> PRDATA[31:8] == 24'h00_0000
    && PRDATA[4:1] == 4'h0) else $error("unused bits");
  a_stack_reset: assert property (s_rd |-> STACK_FAULT_RESET ==
    (PRDATA[5] && STACK_FAULT)) else $error("stack reset");
  a_write_once: assert property (prog_q ##0 s_wr |=>
    $stable({DEBUGGER_ENABLE, EXTENDED_ISA_ENABLE})) else $error("relocked");
  a_por_ones: assert property ($rose(ARST_N) |-> !DEBUGGER_ENABLE
    && EXTENDED_ISA_ENABLE && WATCHDOG_RUN) else $error("por value");
endmodule

// ===== cobl_defs.vh
// constants for the core option byte block: offsets, bit positions, resets
// assumes an apb master with 32-bit data and word-aligned registers
// Contract
// - bit7 one: debugger off, pins are gpio
// - bit6 one: extended isa and indexing on
// - bit0 one forces watchdog, else software enable
// - byte at 300000h; bits 4..1 read zero
// - each bit programmable once per power cycle
// - power-on sets bits to one; others keep
// - power-up copies flash word into byte; here only into implemented bits that software has not yet written
`ifndef COBL_DEFS_VH
`define COBL_DEFS_VH
// ****************************************
// register map
// ****************************************
`define COBL_ADDR_OPTION   32'h0030_0000
`define COBL_ADDR_CTRL     32'h0030_0004
`define COBL_ADDR_STATUS   32'h0030_0008
// ****************************************
// field layout
// ****************************************
`define COBL_BIT_DEBUG     3'h7
`define COBL_BIT_XISA      3'h6
`define COBL_BIT_STKRST    3'h5
`define COBL_BIT_WDOG      3'h0
`define COBL_IMPL_MASK     8'hE1
`define COBL_POR_VALUE     8'hFF
`define COBL_BYTE_ZERO     8'h00
`define COBL_CTRL_SWDT     3'h0
`define COBL_STAT_LOADED   3'h0
`define COBL_STAT_DEBUG    3'h1
`define COBL_STAT_WDOG     3'h2
`define COBL_WORD_ZERO     32'h0000_0000
`endif

// ===== cobl_sync.v
// three-flop synchroniser with agreement filter for pin inputs
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module cobl_sync (
  input  wire clk,
  input  wire arst_n,
  input  wire din,
  output reg  dout
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts only once the last two stages agree
      if (s2_q == s3_q) begin
        dout <= s3_q;
      end
    end
  end
endmodule

// ===== cobl_top.v
// core option byte: write-once configuration byte behind an apb slave
// assumes ARST_N is the power-on reset; SYS_RST_N is any other reset,
// FLASH_CFG_VALID marks the flash word ready after power-up
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "cobl_defs.vh"
module cobl_top (
  input  wire        CLK,
  input  wire        ARST_N,
  input  wire        SYS_RST_N,
  input  wire        FLASH_CFG_VALID,
  input  wire [7:0]  FLASH_CFG_BYTE,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [31:0] PADDR,
  input  wire [31:0] PWDATA,
  input  wire [3:0]  PSTRB,
  output wire        PREADY,
  output reg  [31:0] PRDATA,
  output wire        PSLVERR,
  input  wire        STACK_FAULT,
  input  wire        DBG_PIN_A_I,
  input  wire        DBG_PIN_B_I,
  output wire        DEBUGGER_ENABLE,
  output wire        DEBUG_PINS_OWNED,
  output wire        EXTENDED_ISA_ENABLE,
  output wire        STACK_FAULT_RESET,
  output wire        WATCHDOG_RUN,
  output wire        GPIO_A_IN,
  output wire        GPIO_B_IN
);
  reg  [7:0] opt_q;
  reg  [7:0] locked_q;
  reg        loaded_q;
  reg        sw_wdog_q;
  reg        flash_d1_q;
  reg        flash_d2_q;
  reg        flash_d3_q;
  wire       pin_a_s;
  wire       pin_b_s;
  wire       acc;
  wire       wr;
  wire [7:0] wr_en;
  wire       load_now;
  wire [7:0] load_en;
  reg  [7:0] opt_d;
  reg  [7:0] locked_d;
  reg        loaded_d;
  reg        sw_wdog_d;
  reg [31:0] prdata_d;

  // ****************************************
  // synchronisers
  // ****************************************
  cobl_sync u_sync_a (
    .clk    (CLK),
    .arst_n (ARST_N),
    .din    (DBG_PIN_A_I),
    .dout   (pin_a_s)
  );
  cobl_sync u_sync_b (
    .clk    (CLK),
    .arst_n (ARST_N),
    .din    (DBG_PIN_B_I),
    .dout   (pin_b_s)
  );

  // flash-ready flag comes from another block; filtered like a pin
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flash_d1_q <= 1'b0;
      flash_d2_q <= 1'b0;
      flash_d3_q <= 1'b0;
    end else begin
      flash_d1_q <= FLASH_CFG_VALID;
      flash_d2_q <= flash_d1_q;
      flash_d3_q <= flash_d2_q;
    end
  end
  assign load_now = !loaded_q && flash_d2_q && flash_d3_q;

  // ****************************************
  // apb decode
  // ****************************************
  function is_addr;
    input [31:0] a;
    input [31:0] ref_a;
    begin
      is_addr = (a == ref_a);
    end
  endfunction

  assign acc     = PSEL && PENABLE;
  assign wr      = acc && PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc && !(is_addr(PADDR, `COBL_ADDR_OPTION) ||
                   is_addr(PADDR, `COBL_ADDR_CTRL) ||
                   is_addr(PADDR, `COBL_ADDR_STATUS));
  assign wr_en   = (wr && PSTRB[0] && is_addr(PADDR, `COBL_ADDR_OPTION))
                   ? (`COBL_IMPL_MASK & ~locked_q) : `COBL_BYTE_ZERO;

  // ****************************************
  // option byte storage
  // ****************************************
  // bits that have not yet had their single programming write;
  // unimplemented bits are never opened, so they keep their ones
  assign load_en = `COBL_IMPL_MASK & ~locked_q;

  // next value of the byte, its lock mask and the loaded flag
  // the flash copy counts as the one programming write of each open bit;
  // a bit that software already programmed keeps its value, so a late
  // flash word can never undo a write-once bit
  always @* begin
    opt_d    = opt_q;
    locked_d = locked_q;
    loaded_d = loaded_q;
    if (load_now) begin
      opt_d    = (opt_q & ~load_en) | (FLASH_CFG_BYTE & load_en);
      locked_d = `COBL_IMPL_MASK;
      loaded_d = 1'b1;
    end else begin
      // a write only reaches bits that are still open
      opt_d    = (opt_q & ~wr_en) | (PWDATA[7:0] & wr_en);
      locked_d = locked_q | wr_en;
    end
  end

  // only a power-on reset returns the byte to ones; other resets keep it,
  // which is why SYS_RST_N is not seen by these registers at all
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      opt_q    <= `COBL_POR_VALUE;
      locked_q <= `COBL_BYTE_ZERO;
      loaded_q <= 1'b0;
    end else begin
      opt_q    <= opt_d;
      locked_q <= locked_d;
      loaded_q <= loaded_d;
    end
  end

  // ****************************************
  // software watchdog enable
  // ****************************************
  // cleared by any reset, unlike the option byte; the reset wins over a
  // write in the same cycle, so software must enable it again afterwards
  always @* begin
    sw_wdog_d = sw_wdog_q;
    if (!SYS_RST_N) begin
      sw_wdog_d = 1'b0;
    end else if (wr && PSTRB[0] && is_addr(PADDR, `COBL_ADDR_CTRL)) begin
      sw_wdog_d = PWDATA[`COBL_CTRL_SWDT];
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sw_wdog_q <= 1'b0;
    end else begin
      sw_wdog_q <= sw_wdog_d;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // read data is captured in the setup cycle so it stands for the whole
  // access phase; zero wait states keep the slave simple, at the cost of
  // a register that holds its last value between reads
  always @* begin
    prdata_d = PRDATA;
    if (PSEL && !PENABLE && !PWRITE) begin
      prdata_d = `COBL_WORD_ZERO;
      if (is_addr(PADDR, `COBL_ADDR_OPTION)) begin
        // unimplemented bits always read zero
        prdata_d[7:0] = opt_q & `COBL_IMPL_MASK;
      end else if (is_addr(PADDR, `COBL_ADDR_CTRL)) begin
        prdata_d[`COBL_CTRL_SWDT] = sw_wdog_q;
      end else if (is_addr(PADDR, `COBL_ADDR_STATUS)) begin
        prdata_d[`COBL_STAT_LOADED] = loaded_q;
        prdata_d[`COBL_STAT_DEBUG]  = DEBUGGER_ENABLE;
        prdata_d[`COBL_STAT_WDOG]   = WATCHDOG_RUN;
      end
    end
  end

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= `COBL_WORD_ZERO;
    end else begin
      PRDATA <= prdata_d;
    end
  end

  // ****************************************
  // option decode
  // ****************************************
  // the debugger is selected by a zero bit, the other options by a one;
  // all outputs but STACK_FAULT_RESET are gates on registers, so they settle within one cycle
  assign DEBUGGER_ENABLE     = !opt_q[`COBL_BIT_DEBUG];
  assign DEBUG_PINS_OWNED    = !opt_q[`COBL_BIT_DEBUG];
  // gpio sees zero while the debug link owns the pins
  assign GPIO_A_IN           = opt_q[`COBL_BIT_DEBUG] & pin_a_s;
  assign GPIO_B_IN           = opt_q[`COBL_BIT_DEBUG] & pin_b_s;
  // without the extension the core decodes the legacy set only
  assign EXTENDED_ISA_ENABLE = opt_q[`COBL_BIT_XISA];
  // a stack fault becomes a reset request only when the option allows it
  assign STACK_FAULT_RESET   = opt_q[`COBL_BIT_STKRST] & STACK_FAULT;
  // the hardware enable forces the watchdog; otherwise software decides
  assign WATCHDOG_RUN        = opt_q[`COBL_BIT_WDOG] | sw_wdog_q;
endmodule

// ===== cobl_top_tb_top.sv
// bench for cobl_top: power cycles, one-shot writes, flash load
// assumes cobl_top and cobl_chk are compiled before this file
`timescale 1ns/1ps
`include "cobl_defs.vh"
module cobl_top_tb_top;
  // ****
  // signals and helpers
  // ****
  localparam logic [31:0] OPT = `COBL_ADDR_OPTION;
  logic        CLK = 0, ARST_N = 0, SYS_RST_N = 1, FLASH_CFG_VALID = 0;
  logic        PSEL = 0, PENABLE = 0, PWRITE = 0, STACK_FAULT = 0, e;
  logic        DBG_PIN_A_I = 0, DBG_PIN_B_I = 0;
  logic [7:0]  FLASH_CFG_BYTE = '0, b;
  logic [31:0] PADDR = '0, PWDATA = '0, s = 32'h9859_b5bf, q, r;
  logic [3:0]  PSTRB = 4'h1;
  wire         PREADY, PSLVERR, DEBUGGER_ENABLE, DEBUG_PINS_OWNED;
  wire         EXTENDED_ISA_ENABLE, STACK_FAULT_RESET, WATCHDOG_RUN;
  wire         GPIO_A_IN, GPIO_B_IN;
  wire [31:0]  PRDATA;
  int          errors = 0, samples_checked = 0;
  cobl_top i_cobl_top (.*);
  initial forever #12.5 CLK = ~CLK;
  function logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function logic [31:0] outs(input logic [7:0] v);
    return 32'({~v[7], ~v[7], v[6], v[5] & STACK_FAULT, v[0],
      DBG_PIN_A_I & v[7], DBG_PIN_B_I & v[7]});
  endfunction
  task cmp(input logic [31:0] g, x);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask
  // entered just after a rising edge; an idle cycle follows each transfer
  task apb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK) PENABLE <= 1'b1;
    do @(posedge CLK) n++; while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task look(input logic [7:0] v);
    apb(1'b0, OPT, '0);
    cmp(q, {24'h00_0000, v & 8'hE1});
    cmp(32'({DEBUGGER_ENABLE, DEBUG_PINS_OWNED, EXTENDED_ISA_ENABLE,
      STACK_FAULT_RESET, WATCHDOG_RUN, GPIO_A_IN, GPIO_B_IN}), outs(v));
  endtask
  task conclude();
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      ARST_N <= 1'b0;
      FLASH_CFG_VALID <= 1'b0;
      FLASH_CFG_BYTE <= r[7:0];
      {STACK_FAULT, DBG_PIN_A_I, DBG_PIN_B_I} <= r[18:16];
      repeat (6) @(posedge CLK);
      ARST_N <= 1'b1;
      repeat (6) @(posedge CLK);
      // last cycle loads from flash, which locks before any write
      FLASH_CFG_VALID <= (i == 3);
      repeat (8) @(posedge CLK);
      if (i < 3) begin
        look(8'hFF);
        b = i[0] ? 8'h00 : r[15:8];
        apb(1'b1, OPT, {24'h00_0000, b});
        look(b);
      end else begin
        b = r[7:0];
        look(b);
      end
      apb(1'b1, OPT, {24'h00_0000, ~b});
      look(b);
      // software enable runs the watchdog whatever the option bit says
      apb(1'b1, `COBL_ADDR_CTRL, 32'h0000_0001);
      cmp(32'(WATCHDOG_RUN), 32'h0000_0001);
      apb(1'b0, `COBL_ADDR_STATUS, '0);
      cmp(q, {29'h0000_0000, 1'b1, ~b[7], i == 3});
      SYS_RST_N <= 1'b0;
      @(posedge CLK) SYS_RST_N <= 1'b1;
      @(posedge CLK);
      look(b);
    end
    apb(1'b0, OPT + 32'h0000_000C, '0);
    cmp(32'(e), 32'h0000_0001);
    conclude();
  end
  initial begin
    repeat (5000) @(posedge CLK);
    errors++;
    conclude();
  end
endmodule
bind cobl_top cobl_chk i_cobl_chk (.*);
